// ===== logic/sspc_pkg.sv
// Constants, register map and types of the serial status and pin port block.
// Assumes nothing of its surroundings; every other file names these with sspc_pkg::.
package sspc_pkg;
	// Byte offsets of the registers on the bus.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_TXD = 8'h08;
	localparam logic [7:0] OFS_RXD = 8'h0C;
	localparam logic [7:0] OFS_PORT = 8'h10;
	// Internal register indices.
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_STAT = 3'h1;
	localparam logic [2:0] IDX_TXD = 3'h2;
	localparam logic [2:0] IDX_RXD = 3'h3;
	localparam logic [2:0] IDX_PORT = 3'h4;
	localparam logic [2:0] IDX_NONE = 3'h7;
	// Control register fields.
	localparam int C_RE = 0;
	localparam int C_TE = 1;
	localparam int C_SYNC = 2;
	localparam int C_MP = 3;
	localparam int C_PEN = 4;
	localparam int C_ODD = 5;
	localparam int C_CKLO = 6;
	localparam int C_CKHI = 7;
	// Status register fields.
	localparam int S_TX_MULTIPROC_BIT = 0;
	localparam int S_MPB = 1;
	localparam int S_TRANSMIT_END_FLAG = 2;
	localparam int S_PER = 3;
	localparam int S_RX_FULL_FLAG = 6;
	localparam int S_TX_EMPTY_FLAG = 7;
	// Port register fields.
	localparam int P_BRK_DT = 0;
	localparam int P_BRK_IO = 1;
	localparam int P_CK_DT = 2;
	localparam int P_CK_IO = 3;
	// Reset values.
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h84;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_WACC = 5'h02,
		ST_BRESP = 5'h04,
		ST_RACC = 5'h08,
		ST_RRESP = 5'h10
	} sspc_st_e;

	function automatic logic [2:0] reg_idx(input logic [7:0] a);
		case (a)
			OFS_CTRL: reg_idx = IDX_CTRL;
			OFS_STAT: reg_idx = IDX_STAT;
			OFS_TXD: reg_idx = IDX_TXD;
			OFS_RXD: reg_idx = IDX_RXD;
			OFS_PORT: reg_idx = IDX_PORT;
			default: reg_idx = IDX_NONE;
		endcase
	endfunction
endpackage

// ===== logic/sspc_reg_if.sv
// Register access carrier between the bus slave and the block core.
// Assumes one access strobe at a time, each one clock wide.
`timescale 1ns/10ps
interface sspc_reg_if;
	logic wr;
	logic rd;
	logic [2:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport bus (output wr, output rd, output idx, output wdata, input rdata);
	modport core (input wr, input rd, input idx, input wdata, output rdata);
endinterface

// ===== logic/sspc_axil.sv
// AXI4-Lite slave that turns bus transfers into single-cycle register strobes.
// Assumes the core answers read data combinationally in the strobe cycle.
`timescale 1ns/10ps
module sspc_axil (
	// Clock and control.
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Write channels.
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read channels.
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register side.
	sspc_reg_if.bus rb
);
	sspc_pkg::sspc_st_e st_r;
	logic hit;

	assign rb.idx = (st_r == sspc_pkg::ST_WACC) ? sspc_pkg::reg_idx(awaddr)
		: sspc_pkg::reg_idx(araddr);
	assign hit = (rb.idx != sspc_pkg::IDX_NONE);
	assign rb.wdata = wdata[7:0];
	assign rb.wr = ce && (st_r == sspc_pkg::ST_WACC) && wstrb[0] && hit;
	assign rb.rd = ce && (st_r == sspc_pkg::ST_RACC) && hit;

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= sspc_pkg::ST_IDLE;
			awready <= 1'b0;
			wready <= 1'b0;
			arready <= 1'b0;
			bvalid <= 1'b0;
			rvalid <= 1'b0;
			bresp <= sspc_pkg::RESP_OKAY;
			rresp <= sspc_pkg::RESP_OKAY;
			rdata <= 32'h0000_0000;
		end else if (ce) begin
			case (st_r)
				sspc_pkg::ST_IDLE: begin
					if (awvalid && wvalid) begin
						awready <= 1'b1;
						wready <= 1'b1;
						st_r <= sspc_pkg::ST_WACC;
					end else if (arvalid) begin
						arready <= 1'b1;
						st_r <= sspc_pkg::ST_RACC;
					end
				end
				sspc_pkg::ST_WACC: begin
					awready <= 1'b0;
					wready <= 1'b0;
					bvalid <= 1'b1;
					bresp <= hit ? sspc_pkg::RESP_OKAY : sspc_pkg::RESP_SLVERR;
					st_r <= sspc_pkg::ST_BRESP;
				end
				sspc_pkg::ST_BRESP: begin
					if (bready) begin
						bvalid <= 1'b0;
						st_r <= sspc_pkg::ST_IDLE;
					end
				end
				sspc_pkg::ST_RACC: begin
					arready <= 1'b0;
					rvalid <= 1'b1;
					rresp <= hit ? sspc_pkg::RESP_OKAY : sspc_pkg::RESP_SLVERR;
					rdata <= {{24{1'b0}}, rb.rdata};
					st_r <= sspc_pkg::ST_RRESP;
				end
				sspc_pkg::ST_RRESP: begin
					if (rready) begin
						rvalid <= 1'b0;
						st_r <= sspc_pkg::ST_IDLE;
					end
				end
				default: st_r <= sspc_pkg::ST_IDLE;
			endcase
		end
	end
endmodule

// ===== logic/sspc_top.sv
// Serial status flags and pin port register of a serial interface, reached over AXI4-Lite.
// Assumes a separate shift engine that reports characters and takes transmit data.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module sspc_top (
	// Clock, resets and clock enable.
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic MAN_RST,
	input wire logic STANDBY,
	input wire logic CE,
	// AXI4-Lite register bus.
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Shift engine reports.
	input wire logic RX_DONE,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_PAR,
	input wire logic RX_MPB,
	input wire logic TX_LOAD,
	input wire logic TX_LAST,
	input wire logic TX_BIT,
	input wire logic ENG_SCK,
	input wire logic ENG_SCK_EN,
	// Shift engine controls.
	output logic [7:0] CTRL,
	output logic [7:0] TX_DATA,
	output logic TX_EMPTY,
	output logic TX_MPB,
	output logic RX_HALT,
	output logic TX_HALT,
	// Pins.
	input wire logic RXD,
	output logic TXD,
	input wire logic SCK_IN,
	output logic SCK_OUT,
	output logic SCK_EN
);
	sspc_reg_if rb ();

	logic soft_rst;
	logic [7:0] ctrl_r;
	logic [7:0] txd_r;
	logic [7:0] rxd_r;
	logic tx_empty_flag_r;
	logic rx_full_flag_r;
	logic per_r;
	logic transmit_end_flag_r;
	logic mpb_r;
	logic tx_multiproc_bit_r;
	logic ck_io_r;
	logic ck_dt_r;
	logic brk_io_r;
	logic brk_dt_r;
	logic [2:0] armed_r;
	logic [2:0] flag3;
	logic [2:0] wbit3;
	logic [2:0] clr3;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_tx;
	logic wr_port;
	logic rd_stat;
	logic rd_rx;
	logic te_fall;
	logic rx_take;
	logic par_bad;
	logic txd_pin_r;
	logic sck_out_r;
	logic sck_en_r;
	logic rx_halt_r;
	logic tx_halt_r;
	logic tx_mpb_r;

	sspc_axil u_bus (
		.clk(CLK),
		.rst(SYS_RST),
		.ce(CE),
		.awaddr(AWADDR),
		.awvalid(AWVALID),
		.awready(AWREADY),
		.wdata(WDATA),
		.wstrb(WSTRB),
		.wvalid(WVALID),
		.wready(WREADY),
		.bresp(BRESP),
		.bvalid(BVALID),
		.bready(BREADY),
		.araddr(ARADDR),
		.arvalid(ARVALID),
		.arready(ARREADY),
		.rdata(RDATA),
		.rresp(RRESP),
		.rvalid(RVALID),
		.rready(RREADY),
		.rb(rb)
	);

	// Manual reset and standby act on flags and control, never on the port register.
	assign soft_rst = CE && (MAN_RST || STANDBY);
	assign wr_ctrl = rb.wr && (rb.idx == sspc_pkg::IDX_CTRL);
	assign wr_stat = rb.wr && (rb.idx == sspc_pkg::IDX_STAT);
	assign wr_tx = rb.wr && (rb.idx == sspc_pkg::IDX_TXD);
	assign wr_port = rb.wr && (rb.idx == sspc_pkg::IDX_PORT);
	assign rd_stat = rb.rd && (rb.idx == sspc_pkg::IDX_STAT);
	assign rd_rx = rb.rd && (rb.idx == sspc_pkg::IDX_RXD);
	assign te_fall = wr_ctrl && ctrl_r[sspc_pkg::C_TE] && !rb.wdata[sspc_pkg::C_TE];
	// A character is taken only while reception is enabled and not halted.
	assign rx_take = RX_DONE && ctrl_r[sspc_pkg::C_RE] && !per_r;
	assign par_bad = ctrl_r[sspc_pkg::C_PEN] && !ctrl_r[sspc_pkg::C_SYNC]
		&& ((^{RX_DATA, RX_PAR}) != ctrl_r[sspc_pkg::C_ODD]);

	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst) begin
			ctrl_r <= sspc_pkg::CTRL_RST;
		end else if (CE && wr_ctrl) begin
			ctrl_r <= rb.wdata;
		end
	end

	// A status flag is cleared by a zero write only after it was read as one.
	assign flag3 = {tx_empty_flag_r, rx_full_flag_r, per_r};
	assign wbit3 = {rb.wdata[sspc_pkg::S_TX_EMPTY_FLAG], rb.wdata[sspc_pkg::S_RX_FULL_FLAG],
		rb.wdata[sspc_pkg::S_PER]};
	generate
		for (genvar i = 0; i < 3; i++) begin : g_arm
			always_ff @(posedge CLK) begin
				if (SYS_RST || soft_rst) begin
					armed_r[i] <= 1'b0;
				end else if (CE) begin
					if (rd_stat) begin
						armed_r[i] <= flag3[i];
					end else if (wr_stat) begin
						armed_r[i] <= 1'b0;
					end
				end
			end
			assign clr3[i] = wr_stat && armed_r[i] && !wbit3[i];
		end
	endgenerate

	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst) begin
			tx_empty_flag_r <= sspc_pkg::STAT_RST[sspc_pkg::S_TX_EMPTY_FLAG];
		end else if (CE) begin
			if (TX_LOAD || te_fall) begin
				tx_empty_flag_r <= 1'b1;
			end else if (clr3[2] || wr_tx) begin
				tx_empty_flag_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst) begin
			transmit_end_flag_r <= sspc_pkg::STAT_RST[sspc_pkg::S_TRANSMIT_END_FLAG];
		end else if (CE) begin
			if (te_fall || (TX_LAST && tx_empty_flag_r)) begin
				transmit_end_flag_r <= 1'b1;
			end else if (clr3[2] || wr_tx) begin
				transmit_end_flag_r <= 1'b0;
			end
		end
	end

	// Receive enable is not looked at here, so dropping it keeps the flags.
	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst) begin
			per_r <= sspc_pkg::STAT_RST[sspc_pkg::S_PER];
		end else if (CE) begin
			if (rx_take && par_bad) begin
				per_r <= 1'b1;
			end else if (clr3[0]) begin
				per_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst) begin
			rx_full_flag_r <= sspc_pkg::STAT_RST[sspc_pkg::S_RX_FULL_FLAG];
		end else if (CE) begin
			if (rx_take && !par_bad) begin
				rx_full_flag_r <= 1'b1;
			end else if (clr3[1] || rd_rx) begin
				rx_full_flag_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst) begin
			rxd_r <= sspc_pkg::DATA_RST;
			mpb_r <= sspc_pkg::STAT_RST[sspc_pkg::S_MPB];
		end else if (CE && rx_take) begin
			rxd_r <= RX_DATA;
			if (ctrl_r[sspc_pkg::C_MP] && !ctrl_r[sspc_pkg::C_SYNC]) begin
				mpb_r <= RX_MPB;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst) begin
			txd_r <= sspc_pkg::DATA_RST;
			tx_multiproc_bit_r <= sspc_pkg::STAT_RST[sspc_pkg::S_TX_MULTIPROC_BIT];
		end else if (CE) begin
			if (wr_tx) begin
				txd_r <= rb.wdata;
			end
			if (wr_stat) begin
				tx_multiproc_bit_r <= rb.wdata[sspc_pkg::S_TX_MULTIPROC_BIT];
			end
		end
	end

	// Data bits get a defined start value although none is needed.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ck_io_r <= sspc_pkg::PORT_RST[sspc_pkg::P_CK_IO];
			ck_dt_r <= sspc_pkg::PORT_RST[sspc_pkg::P_CK_DT];
			brk_io_r <= sspc_pkg::PORT_RST[sspc_pkg::P_BRK_IO];
			brk_dt_r <= sspc_pkg::PORT_RST[sspc_pkg::P_BRK_DT];
		end else if (CE && wr_port) begin
			ck_io_r <= rb.wdata[sspc_pkg::P_CK_IO];
			ck_dt_r <= rb.wdata[sspc_pkg::P_CK_DT];
			brk_io_r <= rb.wdata[sspc_pkg::P_BRK_IO];
			brk_dt_r <= rb.wdata[sspc_pkg::P_BRK_DT];
		end
	end

	always_comb begin
		case (rb.idx)
			sspc_pkg::IDX_CTRL: rb.rdata = ctrl_r;
			sspc_pkg::IDX_STAT: rb.rdata = {tx_empty_flag_r, rx_full_flag_r, 2'b00, per_r, transmit_end_flag_r, mpb_r, tx_multiproc_bit_r};
			sspc_pkg::IDX_TXD: rb.rdata = txd_r;
			sspc_pkg::IDX_RXD: rb.rdata = rxd_r;
			sspc_pkg::IDX_PORT: rb.rdata = {4'h0, ck_io_r, SCK_IN, brk_io_r, RXD};
			default: rb.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			txd_pin_r <= 1'b1;
			sck_out_r <= 1'b0;
			sck_en_r <= 1'b0;
			rx_halt_r <= 1'b0;
			tx_halt_r <= 1'b0;
			tx_mpb_r <= 1'b0;
		end else if (CE) begin
			if (brk_io_r) begin
				txd_pin_r <= brk_dt_r;
			end else begin
				txd_pin_r <= ctrl_r[sspc_pkg::C_TE] ? TX_BIT : 1'b1;
			end
			sck_en_r <= ck_io_r || ENG_SCK_EN;
			sck_out_r <= ck_io_r ? ck_dt_r : ENG_SCK;
			rx_halt_r <= per_r;
			tx_halt_r <= per_r && ctrl_r[sspc_pkg::C_SYNC];
			tx_mpb_r <= tx_multiproc_bit_r && ctrl_r[sspc_pkg::C_MP] && !ctrl_r[sspc_pkg::C_SYNC];
		end
	end

	assign CTRL = ctrl_r;
	assign TX_DATA = txd_r;
	assign TX_EMPTY = tx_empty_flag_r;
	assign TX_MPB = tx_mpb_r;
	assign RX_HALT = rx_halt_r;
	assign TX_HALT = tx_halt_r;
	assign TXD = txd_pin_r;
	assign SCK_OUT = sck_out_r;
	assign SCK_EN = sck_en_r;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	property p_per_set;
		CE && !soft_rst && RX_DONE && ctrl_r[sspc_pkg::C_RE] && !per_r && par_bad
			|=> per_r && !$rose(rx_full_flag_r) && (rxd_r == $past(RX_DATA));
	endproperty
	a_per_set: assert property (p_per_set) else $error("parity error not flagged");

	property p_per_hold;
		CE && per_r && !soft_rst && !wr_stat |=> per_r ##1 (per_r || $past(wr_stat || soft_rst));
	endproperty
	a_per_hold: assert property (p_per_hold) else $error("parity flag lost");

	property p_per_clear;
		CE && !soft_rst && wr_stat && armed_r[0] && !rb.wdata[sspc_pkg::S_PER] |=> !per_r;
	endproperty
	a_per_clear: assert property (p_per_clear) else $error("parity flag not cleared");

	property p_halt;
		CE && per_r |=> RX_HALT ##1 (RX_HALT || $past(!per_r || !CE));
	endproperty
	a_halt: assert property (p_halt) else $error("reception not halted");

	property p_transmit_end_flag_ro;
		CE && !soft_rst && wr_stat && rb.wdata[sspc_pkg::S_TRANSMIT_END_FLAG] && !transmit_end_flag_r && !TX_LAST
			|=> !transmit_end_flag_r;
	endproperty
	a_transmit_end_flag_ro: assert property (p_transmit_end_flag_ro) else $error("transmit end was written");

	property p_transmit_end_flag_wr;
		CE && !soft_rst && wr_tx && !TX_LOAD && !TX_LAST |=> !transmit_end_flag_r && !tx_empty_flag_r;
	endproperty
	a_transmit_end_flag_wr: assert property (p_transmit_end_flag_wr) else $error("transmit end not cleared");

	property p_transmit_end_flag_set;
		CE && tx_empty_flag_r && TX_LAST |=> transmit_end_flag_r;
	endproperty
	a_transmit_end_flag_set: assert property (p_transmit_end_flag_set) else $error("transmit end not set");

	property p_mpb;
		CE && !soft_rst && rx_take && ctrl_r[sspc_pkg::C_MP] && !ctrl_r[sspc_pkg::C_SYNC]
			|=> mpb_r == $past(RX_MPB);
	endproperty
	a_mpb: assert property (p_mpb) else $error("multiprocessor bit not captured");

	property p_port_keep;
		CE && soft_rst && !wr_port |=> $stable({ck_io_r, ck_dt_r, brk_io_r, brk_dt_r});
	endproperty
	a_port_keep: assert property (p_port_keep) else $error("port register disturbed");

	property p_sck;
		CE && ck_io_r |=> SCK_EN && (SCK_OUT == $past(ck_dt_r));
	endproperty
	a_sck: assert property (p_sck) else $error("clock pin not driven");

	property p_brk;
		CE && brk_io_r |=> TXD == $past(brk_dt_r);
	endproperty
	a_brk: assert property (p_brk) else $error("break level not on pin");

	property p_port_rd;
		rb.idx == sspc_pkg::IDX_PORT |-> rb.rdata[7:4] == 4'h0 && rb.rdata[2] == SCK_IN
			&& rb.rdata[0] == RXD;
	endproperty
	a_port_rd: assert property (p_port_rd) else $error("port readback wrong");

	c_per: cover property (CE && rx_take && par_bad);
	c_transmit_end_flag: cover property (CE && TX_LAST && tx_empty_flag_r);
	c_brk: cover property (CE && brk_io_r && !brk_dt_r);
	c_clr: cover property (clr3[0]);
endmodule

// ===== testbench/sspc_station.sv
// Model of the shift engine and remote station beside the serial status block.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/10ps
module sspc_station (
	// Clock.
	input wire logic clk,
	// Device pins.
	input wire logic txd,
	input wire logic sck_out,
	input wire logic sck_en,
	output logic rxd,
	output logic sck_in,
	// Engine reports.
	output logic rx_done,
	output logic [7:0] rx_data,
	output logic rx_par,
	output logic rx_mpb,
	output logic tx_load,
	output logic tx_last,
	output logic tx_bit,
	output logic eng_sck,
	output logic eng_sck_en
);
	logic far_sck;
	// The clock pin shows the device level while it drives, else the station level.
	assign sck_in = sck_en ? sck_out : far_sck;
	initial begin
		rxd = 1'b1;
		far_sck = 1'b1;
		rx_done = 1'b0;
		rx_data = 8'h00;
		rx_par = 1'b0;
		rx_mpb = 1'b0;
		tx_load = 1'b0;
		tx_last = 1'b0;
		tx_bit = 1'b1;
		eng_sck = 1'b0;
		eng_sck_en = 1'b0;
	end
	// Character data is only valid with its pulse, so it is inverted afterwards.
	task automatic rx_char(input logic [7:0] d, input logic p, input logic m);
		rx_done <= 1'b1;
		rx_data <= d;
		rx_par <= p;
		rx_mpb <= m;
		@(posedge clk);
		rx_done <= 1'b0;
		rx_data <= ~d;
		rx_par <= ~p;
		rx_mpb <= ~m;
		@(posedge clk);
	endtask
	task automatic tx_pulse(input logic last);
		tx_load <= ~last;
		tx_last <= last;
		@(posedge clk);
		tx_load <= 1'b0;
		tx_last <= 1'b0;
		@(posedge clk);
	endtask
	task automatic set_lines(input logic r, input logic s, input logic b);
		rxd <= r;
		far_sck <= s;
		tx_bit <= b;
		@(posedge clk);
	endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the serial status and pin port block.
// Assumes the station model answers for the engine and the remote side.
`timescale 1ns/10ps
module testbench;
	logic CLK, SYS_RST, MAN_RST, STANDBY, CE;
	logic [7:0] AWADDR, ARADDR, RX_DATA, CTRL, TX_DATA;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP;
	logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
	logic RX_DONE, RX_PAR, RX_MPB, TX_LOAD, TX_LAST, TX_BIT, ENG_SCK, ENG_SCK_EN;
	logic TX_EMPTY, TX_MPB, RX_HALT, TX_HALT, RXD, TXD, SCK_IN, SCK_OUT, SCK_EN;
	int mismatches = 0;
	int checks_done = 0;
	localparam logic [7:0] C = sspc_pkg::OFS_CTRL;
	localparam logic [7:0] S = sspc_pkg::OFS_STAT;
	localparam logic [7:0] P = sspc_pkg::OFS_PORT;
	localparam logic [7:0] R = sspc_pkg::OFS_RXD;
	localparam logic [1:0] OK = sspc_pkg::RESP_OKAY;

	sspc_top sspc_top_i (.CLK, .SYS_RST, .MAN_RST, .STANDBY, .CE, .AWADDR, .AWVALID, .AWREADY,
		.WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
		.RDATA, .RRESP, .RVALID, .RREADY, .RX_DONE, .RX_DATA, .RX_PAR, .RX_MPB, .TX_LOAD, .TX_LAST,
		.TX_BIT, .ENG_SCK, .ENG_SCK_EN, .CTRL, .TX_DATA, .TX_EMPTY, .TX_MPB, .RX_HALT, .TX_HALT,
		.RXD, .TXD, .SCK_IN, .SCK_OUT, .SCK_EN);
	sspc_station sspc_station_i (.clk(CLK), .txd(TXD), .sck_out(SCK_OUT), .sck_en(SCK_EN),
		.rxd(RXD), .sck_in(SCK_IN), .rx_done(RX_DONE), .rx_data(RX_DATA), .rx_par(RX_PAR),
		.rx_mpb(RX_MPB), .tx_load(TX_LOAD), .tx_last(TX_LAST), .tx_bit(TX_BIT),
		.eng_sck(ENG_SCK), .eng_sck_en(ENG_SCK_EN));

	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit aw, w;
		aw = 0;
		w = 0;
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		while (!(aw && w)) begin
			@(posedge CLK);
			if (AWREADY === 1'b1) begin
				aw = 1;
				AWVALID <= 1'b0;
			end
			if (WREADY === 1'b1) begin
				w = 1;
				WVALID <= 1'b0;
			end
		end
		do @(posedge CLK); while (BVALID !== 1'b1);
		BREADY <= 1'b0;
		chk("write response", {30'h0000_0000, er}, {30'h0000_0000, BRESP});
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do @(posedge CLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge CLK); while (RVALID !== 1'b1);
		RREADY <= 1'b0;
		chk(n, e, RDATA);
		chk("read response", {30'h0000_0000, er}, {30'h0000_0000, RRESP});
	endtask
	task automatic pulse_in(input bit stby);
		if (stby) STANDBY <= 1'b1;
		else MAN_RST <= 1'b1;
		tick(1);
		STANDBY <= 1'b0;
		MAN_RST <= 1'b0;
		tick(1);
	endtask

	task automatic t_reset();
		rd("status", S, 32'h0000_0084, OK);
		rd("port", P, 32'h0000_0005, OK);
		rd("unmapped", 8'h14, 32'h0000_0000, sspc_pkg::RESP_SLVERR);
		wr(8'h14, 32'h0000_00FF, sspc_pkg::RESP_SLVERR);
	endtask
	task automatic t_parity();
		wr(C, 32'h0000_0011, OK);
		sspc_station_i.rx_char(8'h03, 1'b1, 1'b0);
		tick(2);
		rd("status", S, 32'h0000_008C, OK);
		rd("rx data", R, 32'h0000_0003, OK);
		chk("rx halt", 32'h0000_0001, {31'h0000_0000, RX_HALT});
		chk("tx halt", 32'h0000_0000, {31'h0000_0000, TX_HALT});
		sspc_station_i.rx_char(8'h05, 1'b0, 1'b0);
		rd("rx data", R, 32'h0000_0003, OK);
		wr(C, 32'h0000_0014, OK);
		rd("status", S, 32'h0000_008C, OK);
		chk("tx halt", 32'h0000_0001, {31'h0000_0000, TX_HALT});
		wr(S, 32'h0000_00F6, OK);
		rd("status", S, 32'h0000_0084, OK);
		wr(C, 32'h0000_0011, OK);
		sspc_station_i.rx_char(8'h05, 1'b0, 1'b0);
		tick(2);
		rd("status", S, 32'h0000_00C4, OK);
		rd("rx data", R, 32'h0000_0005, OK);
		wr(C, 32'h0000_0031, OK);
		sspc_station_i.rx_char(8'h07, 1'b0, 1'b0);
		tick(2);
		rd("status", S, 32'h0000_00C4, OK);
		rd("rx data", R, 32'h0000_0007, OK);
		sspc_station_i.rx_char(8'h06, 1'b0, 1'b0);
		tick(2);
		rd("status", S, 32'h0000_0088 | 32'h0000_0004, OK);
		pulse_in(1'b1);
		chk("control", 32'h0000_0000, {24'h0000_00, CTRL});
		rd("status", S, 32'h0000_0084, OK);
	endtask
	task automatic t_transmit_end_flag();
		wr(S, 32'h0000_0082, OK);
		rd("status", S, 32'h0000_0084, OK);
		wr(S, 32'h0000_007E, OK);
		rd("status", S, 32'h0000_0000, OK);
		wr(S, 32'h0000_0004, OK);
		rd("status", S, 32'h0000_0000, OK);
		sspc_station_i.tx_pulse(1'b0);
		sspc_station_i.tx_pulse(1'b1);
		rd("status", S, 32'h0000_0084, OK);
		wr(sspc_pkg::OFS_TXD, 32'h0000_005A, OK);
		chk("tx data", 32'h0000_005A, {24'h0000_00, TX_DATA});
		sspc_station_i.tx_pulse(1'b1);
		rd("status", S, 32'h0000_0000, OK);
		wr(C, 32'h0000_0002, OK);
		wr(C, 32'h0000_0000, OK);
		rd("status", S, 32'h0000_0084, OK);
		chk("tx empty", 32'h0000_0001, {31'h0000_0000, TX_EMPTY});
	endtask
	task automatic t_mpb();
		wr(C, 32'h0000_000B, OK);
		sspc_station_i.rx_char(8'h11, 1'b0, 1'b1);
		tick(2);
		rd("status", S, 32'h0000_00C6, OK);
		wr(C, 32'h0000_000A, OK);
		rd("status", S, 32'h0000_00C6, OK);
		wr(S, 32'h0000_00C7, OK);
		tick(2);
		chk("tx mpb", 32'h0000_0001, {31'h0000_0000, TX_MPB});
		rd("status", S, 32'h0000_00C7, OK);
		wr(C, 32'h0000_000E, OK);
		tick(2);
		chk("tx mpb", 32'h0000_0000, {31'h0000_0000, TX_MPB});
		CE <= 1'b0;
		pulse_in(1'b1);
		CE <= 1'b1;
		chk("control", 32'h0000_000E, {24'h0000_00, CTRL});
		rd("status", S, 32'h0000_00C7, OK);
	endtask
	task automatic t_port();
		wr(C, 32'h0000_0000, OK);
		wr(P, 32'h0000_000F, OK);
		sspc_station_i.set_lines(1'b0, 1'b0, 1'b0);
		tick(1);
		chk("pins", 32'h0000_0007, {29'h0000_0000, SCK_EN, SCK_OUT, TXD});
		rd("port", P, 32'h0000_000E, OK);
		wr(P, 32'h0000_000A, OK);
		sspc_station_i.set_lines(1'b1, 1'b1, 1'b0);
		tick(1);
		chk("pins", 32'h0000_0004, {29'h0000_0000, SCK_EN, SCK_OUT, TXD});
		rd("port", P, 32'h0000_000B, OK);
		wr(P, 32'h0000_0005, OK);
		sspc_station_i.set_lines(1'b1, 1'b0, 1'b0);
		tick(1);
		chk("pins", 32'h0000_0001, {29'h0000_0000, SCK_EN, SCK_OUT, TXD});
		rd("port", P, 32'h0000_0001, OK);
		wr(C, 32'h0000_0002, OK);
		tick(2);
		chk("tx pin", 32'h0000_0000, {31'h0000_0000, TXD});
		wr(C, 32'h0000_0000, OK);
		wr(P, 32'h0000_000A, OK);
		pulse_in(1'b0);
		rd("port", P, 32'h0000_000B, OK);
		pulse_in(1'b1);
		rd("port", P, 32'h0000_000B, OK);
		SYS_RST <= 1'b1;
		tick(5);
		SYS_RST <= 1'b0;
		tick(1);
		rd("port", P, 32'h0000_0001, OK);
	endtask

	initial begin
		SYS_RST = 1'b1;
		MAN_RST = 1'b0;
		STANDBY = 1'b0;
		CE = 1'b1;
		AWADDR = 8'h00;
		ARADDR = 8'h00;
		WDATA = 32'h0000_0000;
		WSTRB = 4'hF;
		AWVALID = 1'b0;
		WVALID = 1'b0;
		BREADY = 1'b0;
		ARVALID = 1'b0;
		RREADY = 1'b0;
		tick(5);
		SYS_RST <= 1'b0;
		tick(1);
		t_reset();
		t_parity();
		t_transmit_end_flag();
		t_mpb();
		t_port();
		final_report();
	end
	initial begin
		#(100 * 5000);
		mismatches++;
		final_report();
	end
endmodule
